/* File: inc/mct_params.svh */
// register map, field positions and reset values of the capture/compare timer
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH

`define MCT_NUM_CH        3
`define MCT_NUM_GR        4
`define MCT_NUM_PINS      12
`define MCT_NUM_EXT       4
`define MCT_CNT_W         16

// ---------------------------------------------------------------
// address map: addr[7:4] is the page, addr[3:0] the register
// ---------------------------------------------------------------
`define MCT_GLOBAL_PAGE   4'h0
`define MCT_REG_RUN       4'h0
`define MCT_REG_SYNC      4'h1
`define MCT_REG_CTRL      4'h0
`define MCT_REG_IO        4'h1
`define MCT_REG_IER       4'h2
`define MCT_REG_STAT      4'h3
`define MCT_REG_CNT       4'h4
`define MCT_REG_GR_BIT    3

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MCT_CTRL_CLR_MSB  2
`define MCT_CTRL_CLR_LSB  0
`define MCT_CTRL_MODE_MSB 4
`define MCT_CTRL_MODE_LSB 3
`define MCT_CTRL_BUF_A    5
`define MCT_CTRL_BUF_B    6
`define MCT_IO_CAPTURE    3
`define MCT_IO_INIT       2
`define MCT_STAT_OVF      4
`define MCT_STAT_UNF      5
`define MCT_STAT_DIR      6
`define MCT_IER_OVF       4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MCT_CNT_RESET     16'h0000
`define MCT_CNT_MAX       16'hffff
`define MCT_GR_RESET      16'hffff

`endif

/* File: inc/mct_pkg.sv */
// types of the capture/compare timer
`include "mct_params.svh"

package mct_pkg;

    typedef enum logic [1:0] {
        MCT_MODE_NORMAL = 2'b00,
        MCT_MODE_PWM    = 2'b01,
        MCT_MODE_PHASE  = 2'b11
    } mct_mode_t;

    typedef enum logic [2:0] {
        MCT_CLR_NONE = 3'b000,
        MCT_CLR_GR0  = 3'b001,
        MCT_CLR_GR1  = 3'b010,
        MCT_CLR_SYNC = 3'b011,
        MCT_CLR_GR2  = 3'b101,
        MCT_CLR_GR3  = 3'b110
    } mct_clr_t;

    typedef enum logic [1:0] {
        MCT_ACT_KEEP   = 2'b00,
        MCT_ACT_LOW    = 2'b01,
        MCT_ACT_HIGH   = 2'b10,
        MCT_ACT_TOGGLE = 2'b11
    } mct_act_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mct_bus_req_t;

    typedef struct packed {
        logic [`MCT_NUM_CH-1:0]                                  run;
        logic [`MCT_NUM_CH-1:0]                                  sync;
        logic [`MCT_NUM_CH-1:0][7:0]                             ctrl;
        logic [`MCT_NUM_CH-1:0][15:0]                            io;
        logic [`MCT_NUM_CH-1:0][4:0]                             ier;
        logic [`MCT_NUM_CH-1:0][`MCT_NUM_GR-1:0]                 flag;
        logic [`MCT_NUM_CH-1:0]                                  ovf;
        logic [`MCT_NUM_CH-1:0]                                  unf;
        logic [`MCT_NUM_CH-1:0]                                  dir;
        logic [`MCT_NUM_CH-1:0][`MCT_CNT_W-1:0]                  cnt;
        logic [`MCT_NUM_CH-1:0][`MCT_NUM_GR-1:0][`MCT_CNT_W-1:0] gr;
        logic [`MCT_NUM_PINS-1:0]                                pin_o;
        logic [`MCT_NUM_PINS-1:0]                                pin_oe;
        logic [15:0]                                             rdata;
        logic [`MCT_NUM_CH-1:0]                                  irq;
    } mct_state_t;

endpackage : mct_pkg

/* File: core/mct_pin_sync.sv */
// two-stage synchroniser for pins with a delayed copy for edge detection
`timescale 1ns/100ps

module mct_pin_sync #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // raw pins
    input  wire logic [W-1:0] pin_i,
    // synchronised level and the same one clock earlier
    output logic [W-1:0]      level,
    output logic [W-1:0]      level_old
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] lvl;
        logic [W-1:0] old;
    } mct_sync_state_t;

    mct_sync_state_t st;
    mct_sync_state_t next_st;

    // meta is read by lvl only; edges come from lvl against old
    always_comb begin
        next_st      = st;
        next_st.meta = pin_i;
        next_st.lvl  = st.meta;
        next_st.old  = st.lvl;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level     = st.lvl;
    assign level_old = st.old;

endmodule : mct_pin_sync

/* File: core/mct_timer.sv */
// three-channel 16-bit capture/compare timer with register port
`timescale 1ns/100ps
`include "mct_params.svh"

// What this block does
// - run bit set starts upward counting
// - after reset counters stopped, no clearing
// - wrap from all ones sets overflow flag
// - overflow flag with enable raises interrupt
// - counting continues from zero after overflow
// - compare-match clear sets flag, zeroes counter
// - match/capture flag with enable requests interrupt
// - compare match drives pin low, high, toggle
// - requested level equal to pin: no change
// - selected input edge copies counter to register
// - capture edge rising, falling or both
// - capture may clear the counter
// - counter write to a synchronised channel presets all synchronised channels
// - synchronised channels clear together
// - each channel selectable for synchronous operation
// - buffered compare loads buffer into register
// - buffered capture shifts old value to buffer
// - channels 1, 2 count encoder phases
// - pwm mode gives duty zero to full
// - each register is capture or compare
// - reset zeroes counters, general registers all ones
// - stopping holds the pin's compare level
// - buffers pair first/third, second/fourth, channel 0
module mct_timer
    import mct_pkg::*;
(
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    // register port
    input  wire mct_bus_req_t             bus_req,
    output logic [15:0]                   bus_rdata,
    // capture/compare pins, four per channel
    input  wire logic [`MCT_NUM_PINS-1:0] cc_pin_i,
    output logic [`MCT_NUM_PINS-1:0]      cc_pin_o,
    output logic [`MCT_NUM_PINS-1:0]      cc_pin_oe,
    // encoder inputs: a/b of channel 1, then a/b of channel 2
    input  wire logic [`MCT_NUM_EXT-1:0]  ext_clk_i,
    // interrupt requests, one per channel
    output logic [`MCT_NUM_CH-1:0]        irq_req
);

    mct_state_t st;
    mct_state_t next_st;

    logic [`MCT_NUM_CH-1:0]                  tick;
    logic [`MCT_NUM_CH-1:0]                  up;
    logic [`MCT_NUM_CH-1:0]                  pwm;
    logic [`MCT_NUM_CH-1:0]                  clr_own;
    logic [`MCT_NUM_CH-1:0]                  clr_all;
    logic [`MCT_NUM_CH-1:0]                  ovf_ev;
    logic [`MCT_NUM_CH-1:0]                  unf_ev;
    logic [`MCT_NUM_CH-1:0][`MCT_NUM_GR-1:0] gr_on;
    logic [`MCT_NUM_CH-1:0][`MCT_NUM_GR-1:0] match;
    logic [`MCT_NUM_CH-1:0][`MCT_NUM_GR-1:0] capt;
    logic [1:0]                              buf_en;
    logic [15:0]                             pin_lvl;
    logic [15:0]                             pin_old;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    mct_pin_sync #(
        .W (16)
    ) u_pin_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pin_i     ({ext_clk_i, cc_pin_i}),
        .level     (pin_lvl),
        .level_old (pin_old)
    );

    // pairs are fixed on channel 0: 0 with 2, 1 with 3
    assign buf_en = {st.ctrl[0][`MCT_CTRL_BUF_B], st.ctrl[0][`MCT_CTRL_BUF_A]};

    // ---------------------------------------------------------------
    // per-channel event decode
    // ---------------------------------------------------------------
    for (genvar c = 0; c < `MCT_NUM_CH; c++) begin : g_ch
        localparam int AI = (c == 0) ? 12 : 12 + 2 * (c - 1);
        mct_clr_t               src;
        mct_mode_t              mode;
        logic                   phase;
        logic                   qstep;
        logic [`MCT_NUM_GR-1:0] hit;

        assign src   = mct_clr_t'(st.ctrl[c][`MCT_CTRL_CLR_MSB:`MCT_CTRL_CLR_LSB]);
        assign mode  = mct_mode_t'(st.ctrl[c][`MCT_CTRL_MODE_MSB:`MCT_CTRL_MODE_LSB]);
        assign phase = (c != 0) && (mode == MCT_MODE_PHASE);
        assign pwm[c] = (mode == MCT_MODE_PWM);
        // exactly one of the two encoder lines moved
        assign qstep = pin_lvl[AI] ^ pin_old[AI] ^ pin_lvl[AI+1] ^ pin_old[AI+1];
        assign tick[c] = st.run[c] && (!phase || qstep);
        assign up[c]   = !phase || (pin_lvl[AI] ^ pin_old[AI+1]);

        for (genvar k = 0; k < `MCT_NUM_GR; k++) begin : g_gr
            localparam int P = 4 * c + k;
            logic cap_mode;
            logic rise;
            logic fall;
            logic [1:0] esel;

            // a register serving as buffer has no event of its own
            assign gr_on[c][k] = (c == 0) ? (k < 2 || !buf_en[k % 2]) : (k < 2);
            assign cap_mode = st.io[c][4*k+`MCT_IO_CAPTURE];
            assign esel = st.io[c][4*k +: 2];
            assign rise = pin_lvl[P] & ~pin_old[P];
            assign fall = ~pin_lvl[P] & pin_old[P];
            assign match[c][k] = gr_on[c][k] && !cap_mode && tick[c] && st.cnt[c] == st.gr[c][k];
            assign capt[c][k] = gr_on[c][k] && cap_mode && st.run[c]
                                && (esel[1] ? (rise | fall) : (esel[0] ? fall : rise));
        end

        assign hit = match[c] | capt[c];
        assign clr_own[c] = (src == MCT_CLR_GR0 && hit[0]) || (src == MCT_CLR_GR1 && hit[1])
                          || (src == MCT_CLR_GR2 && hit[2]) || (src == MCT_CLR_GR3 && hit[3]);
        assign clr_all[c] = clr_own[c] || (src == MCT_CLR_SYNC && st.sync[c]
                            && |(clr_own & st.sync & ~(3'b001 << c)));
        assign ovf_ev[c] = tick[c] && up[c] && st.cnt[c] == `MCT_CNT_MAX && !clr_all[c];
        assign unf_ev[c] = tick[c] && !up[c] && st.cnt[c] == `MCT_CNT_RESET && !clr_all[c];
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [3:0]             page;
        logic [3:0]             sel;
        logic [`MCT_NUM_CH-1:0] cnt_direct;
        logic [`MCT_NUM_CH-1:0] cnt_wr;
        int                     p;
        next_st       = st;
        page          = bus_req.addr[7:4];
        sel           = bus_req.addr[3:0];
        cnt_direct    = '0;
        cnt_wr        = '0;
        p             = 0;
        next_st.rdata = '0;

        // software writes come first so hardware events can win over them; a counter write beats clear and count
        if (bus_req.wr && page == `MCT_GLOBAL_PAGE) begin
            if (sel == `MCT_REG_RUN) begin
                next_st.run = bus_req.wdata[`MCT_NUM_CH-1:0];
            end
            if (sel == `MCT_REG_SYNC) begin
                next_st.sync = bus_req.wdata[`MCT_NUM_CH-1:0];
            end
        end
        for (int c = 0; c < `MCT_NUM_CH; c++) begin
            if (bus_req.wr && page == 4'(c + 1)) begin
                case (sel)
                    `MCT_REG_CTRL: begin
                        next_st.ctrl[c] = bus_req.wdata[7:0];
                    end
                    `MCT_REG_IO: begin
                        next_st.io[c] = bus_req.wdata;
                        // a stopped channel takes the initial level at once
                        if (!st.run[c]) begin
                            for (int k = 0; k < `MCT_NUM_GR; k++) begin
                                next_st.pin_o[4*c+k] = bus_req.wdata[4*k+`MCT_IO_INIT];
                            end
                        end
                    end
                    `MCT_REG_IER: begin
                        next_st.ier[c] = bus_req.wdata[4:0];
                    end
                    `MCT_REG_STAT: begin
                        next_st.flag[c] = st.flag[c] & bus_req.wdata[`MCT_NUM_GR-1:0];
                        next_st.ovf[c]  = st.ovf[c] & bus_req.wdata[`MCT_STAT_OVF];
                        next_st.unf[c]  = st.unf[c] & bus_req.wdata[`MCT_STAT_UNF];
                    end
                    `MCT_REG_CNT: begin
                        cnt_direct[c] = 1'b1;
                    end
                    default: begin
                        if (sel[`MCT_REG_GR_BIT] && (c == 0 || !sel[1])) begin
                            next_st.gr[c][sel[1:0]] = bus_req.wdata;
                        end
                    end
                endcase
            end
        end
        cnt_wr = cnt_direct | (st.sync & {`MCT_NUM_CH{|(cnt_direct & st.sync)}});

        // counters, flags, registers and pins
        for (int c = 0; c < `MCT_NUM_CH; c++) begin
            if (cnt_wr[c]) begin
                next_st.cnt[c] = bus_req.wdata;
            end else if (clr_all[c]) begin
                next_st.cnt[c] = `MCT_CNT_RESET;
            end else if (tick[c]) begin
                next_st.cnt[c] = up[c] ? st.cnt[c] + 16'h0001 : st.cnt[c] - 16'h0001;
            end
            if (tick[c]) begin
                next_st.dir[c] = up[c];
            end
            if (ovf_ev[c]) begin
                next_st.ovf[c] = 1'b1;
            end
            if (unf_ev[c]) begin
                next_st.unf[c] = 1'b1;
            end
            for (int k = 0; k < `MCT_NUM_GR; k++) begin
                // in pwm mode the odd register steers its even neighbour's pin
                p = (pwm[c] && (k % 2 == 1)) ? 4 * c + k - 1 : 4 * c + k;
                if (match[c][k]) begin
                    next_st.flag[c][k] = 1'b1;
                    case (mct_act_t'(st.io[c][4*k +: 2]))
                        MCT_ACT_LOW:    next_st.pin_o[p] = 1'b0;
                        MCT_ACT_HIGH:   next_st.pin_o[p] = 1'b1;
                        MCT_ACT_TOGGLE: next_st.pin_o[p] = ~next_st.pin_o[p];
                        MCT_ACT_KEEP:   next_st.pin_o[p] = next_st.pin_o[p];
                    endcase
                    if (c == 0 && k < 2 && buf_en[k % 2]) begin
                        next_st.gr[0][k] = st.gr[0][(k + 2) % 4];
                    end
                end
                if (capt[c][k]) begin
                    next_st.flag[c][k] = 1'b1;
                    next_st.gr[c][k]   = st.cnt[c];
                    if (c == 0 && k < 2 && buf_en[k % 2]) begin
                        next_st.gr[0][(k + 2) % 4] = st.gr[0][k];
                    end
                end
            end
        end

        // interrupt requests follow the new state, pin drive the new io but the current ctrl
        for (int c = 0; c < `MCT_NUM_CH; c++) begin
            for (int k = 0; k < `MCT_NUM_GR; k++) begin
                next_st.pin_oe[4*c+k] = gr_on[c][k] && !next_st.io[c][4*k+`MCT_IO_CAPTURE]
                                        && !(pwm[c] && (k % 2 == 1));
            end
            next_st.irq[c] = |(next_st.flag[c] & next_st.ier[c][`MCT_NUM_GR-1:0])
                           || ((next_st.ovf[c] || next_st.unf[c]) && next_st.ier[c][`MCT_IER_OVF]);
        end

        // read data stand for the single cycle after the strobe
        if (bus_req.rd && page == `MCT_GLOBAL_PAGE) begin
            if (sel == `MCT_REG_RUN) begin
                next_st.rdata = {13'h0000, st.run};
            end else if (sel == `MCT_REG_SYNC) begin
                next_st.rdata = {13'h0000, st.sync};
            end
        end
        for (int c = 0; c < `MCT_NUM_CH; c++) begin
            if (bus_req.rd && page == 4'(c + 1)) begin
                case (sel)
                    `MCT_REG_CTRL: next_st.rdata = {8'h00, st.ctrl[c]};
                    `MCT_REG_IO:   next_st.rdata = st.io[c];
                    `MCT_REG_IER:  next_st.rdata = {11'h000, st.ier[c]};
                    `MCT_REG_STAT: next_st.rdata = {9'h000, st.dir[c], st.unf[c], st.ovf[c], st.flag[c]};
                    `MCT_REG_CNT:  next_st.rdata = st.cnt[c];
                    default: begin
                        if (sel[`MCT_REG_GR_BIT] && (c == 0 || !sel[1])) begin
                            next_st.rdata = st.gr[c][sel[1:0]];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
            for (int c = 0; c < `MCT_NUM_CH; c++) begin
                for (int k = 0; k < `MCT_NUM_GR; k++) begin
                    st.gr[c][k] <= `MCT_GR_RESET;
                end
            end
        end else begin
            st <= next_st;
        end
    end

    assign bus_rdata = st.rdata;
    assign cc_pin_o  = st.pin_o;
    assign cc_pin_oe = st.pin_oe;
    assign irq_req   = st.irq;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    logic cnt0_wr;
    logic clr0_a_sel;
    assign cnt0_wr    = bus_req.wr && bus_req.addr == {4'h1, `MCT_REG_CNT};
    assign clr0_a_sel = st.ctrl[0][`MCT_CTRL_CLR_MSB:`MCT_CTRL_CLR_LSB] == MCT_CLR_GR0;

    sequence s_wrapped;
        ##1 (st.ovf[0] && st.cnt[0] == `MCT_CNT_RESET);
    endsequence

    sequence s_restart;
        ##1 (st.cnt[0] == `MCT_CNT_RESET && st.flag[0][0]);
    endsequence

    count_step_a: assert property (st.run[0] && !clr_all[0] && !bus_req.wr
        |=> st.cnt[0] == $past(st.cnt[0]) + 16'h0001)
        else $error("running counter did not step by one");

    stop_hold_a: assert property (!st.run[0] && !clr_all[0] && !bus_req.wr
        |=> $stable(st.cnt[0]))
        else $error("stopped counter moved");

    overflow_wrap_a: assert property (ovf_ev[0] |-> s_wrapped)
        else $error("overflow did not wrap and flag");

    overflow_irq_a: assert property (st.ovf[0] && st.ier[0][`MCT_IER_OVF] |-> irq_req[0])
        else $error("overflow interrupt missing");

    match_clear_a: assert property (match[0][0] && clr0_a_sel && !bus_req.wr |-> s_restart)
        else $error("compare clear failed");

    match_irq_a: assert property (st.flag[0][0] && st.ier[0][0] |-> irq_req[0])
        else $error("match interrupt missing");

    toggle_pin_a: assert property (match[0][0] && !pwm[0] && st.io[0][1:0] == 2'b11 && !bus_req.wr
        |=> cc_pin_o[0] != $past(cc_pin_o[0]))
        else $error("toggle output did not change");

    same_level_a: assert property (match[0][0] && !pwm[0] && st.io[0][1:0] == 2'b10 && st.pin_o[0]
        && !bus_req.wr |=> cc_pin_o[0])
        else $error("high level changed");

    capture_copy_a: assert property (capt[1][1] && !bus_req.wr
        |=> st.gr[1][1] == $past(st.cnt[1]))
        else $error("capture did not copy counter");

    sync_preset_a: assert property (cnt0_wr && st.sync[0] && st.sync[1]
        |=> st.cnt[1] == st.cnt[0])
        else $error("synchronous preset missed");

    buffer_load_a: assert property (match[0][0] && buf_en[0] && !bus_req.wr
        |=> st.gr[0][0] == $past(st.gr[0][2]))
        else $error("buffered compare did not reload");

    reset_value_a: assert property ($rose(reset_n) |-> st.cnt[1] == `MCT_CNT_RESET
        && st.gr[1][0] == `MCT_GR_RESET)
        else $error("reset values wrong");

endmodule : mct_timer

/* File: tb/mct_pin_model.sv */
// far-side pin model: external sources and resolved pin levels
`timescale 1ns/100ps
`include "mct_params.svh"

module mct_pin_model (
    // levels the outside world wants to put on the pins
    input  wire logic [`MCT_NUM_PINS-1:0] drive,
    // encoder lines as the bench steps them
    input  wire logic [`MCT_NUM_EXT-1:0]  enc,
    // timer side of the pins
    input  wire logic [`MCT_NUM_PINS-1:0] cc_pin_o,
    input  wire logic [`MCT_NUM_PINS-1:0] cc_pin_oe,
    output logic [`MCT_NUM_PINS-1:0]      cc_pin_i,
    output logic [`MCT_NUM_EXT-1:0]       ext_clk_i
);
    // a pin the timer drives shows the timer's level, else the source
    assign cc_pin_i  = (cc_pin_oe & cc_pin_o) | (~cc_pin_oe & drive);
    // encoder lines rest low until the bench moves them
    assign ext_clk_i = enc;
endmodule : mct_pin_model

/* File: tb/tb.sv */
// self-checking bench of the capture/compare timer
`timescale 1ns/100ps
`include "mct_params.svh"

module tb
    import mct_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    mct_bus_req_t bus_req = '0;
    logic [15:0] bus_rdata;
    logic [11:0] cc_pin_i, cc_pin_o, cc_pin_oe, drive = 12'h000;
    logic [3:0] ext_clk_i;
    logic [3:0] enc = 4'h0;
    logic [2:0] irq_req;
    logic [15:0] rv, cv;
    int miscompares = 0;
    int num_checks = 0;

    always #4 sys_clk = ~sys_clk;

    mct_timer i_mct_timer (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o), .cc_pin_oe(cc_pin_oe), .ext_clk_i(ext_clk_i), .irq_req(irq_req));
    mct_pin_model i_mct_pin_model (.drive(drive), .enc(enc), .cc_pin_o(cc_pin_o), .cc_pin_oe(cc_pin_oe),
        .cc_pin_i(cc_pin_i), .ext_clk_i(ext_clk_i));

    // ----------------------------------------
    // bus cycles and comparison
    // ----------------------------------------
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd

    task automatic wrap_up;
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(8'h14, rv); chk(rv === 16'h0000, "counter reset");
        rd(8'h18, rv); chk(rv === 16'hffff, "general reg reset");
        rd(8'h10, rv); chk(rv === 16'h0000, "no clear source");
        rd(8'h2a, rv); chk(rv === 16'h0000, "unmapped read");
        repeat (4) @(posedge sys_clk);
        rd(8'h14, rv); chk(rv === 16'h0000, "stopped counter holds");
    endtask : t_reset

    task automatic t_overflow;
        wr(8'h14, 16'hfffd);
        wr(8'h12, 16'h0010);
        wr(8'h00, 16'h0001);
        repeat (10) @(posedge sys_clk);
        wr(8'h00, 16'h0000);
        rd(8'h13, rv); chk(rv[4] === 1'b1, "overflow flag");
        chk(irq_req[0] === 1'b1, "overflow irq");
        rd(8'h14, rv); chk(rv !== 16'h0000 && rv < 16'h0010, "count after wrap");
        wr(8'h12, 16'h0000);
        wr(8'h13, 16'h0000);
        repeat (2) @(posedge sys_clk);
        chk(irq_req[0] === 1'b0, "irq drops with flag");
    endtask : t_overflow

    // period of clear-on-match is reg+1, pin set high on match
    task automatic t_compare;
        wr(8'h14, 16'h0000);
        wr(8'h18, 16'h0008);
        wr(8'h10, 16'h0001);
        wr(8'h11, 16'h0002);
        wr(8'h12, 16'h0001);
        chk(cc_pin_o[0] === 1'b0, "initial level");
        wr(8'h00, 16'h0001);
        repeat (30) @(posedge sys_clk);
        wr(8'h00, 16'h0000);
        rd(8'h13, rv); chk(rv[0] === 1'b1, "match flag");
        chk(irq_req[0] === 1'b1, "match irq");
        rd(8'h14, rv); chk(rv <= 16'h0008, "cleared on match");
        repeat (5) @(posedge sys_clk);
        chk(cc_pin_o[0] === 1'b1 && cc_pin_oe[0] === 1'b1, "pin high held");
    endtask : t_compare

    task automatic t_capture;
        wr(8'h21, 16'h0080);
        wr(8'h20, 16'h0002);
        wr(8'h00, 16'h0002);
        repeat (20) @(posedge sys_clk);
        drive <= 12'h020;
        repeat (10) @(posedge sys_clk);
        wr(8'h00, 16'h0000);
        rd(8'h24, cv); chk(cv === 16'h0009, "counter restarted by capture");
        rd(8'h29, rv); chk(rv === 16'h0016, "captured count");
        rd(8'h23, rv); chk(rv[1] === 1'b1, "capture flag");
    endtask : t_capture

    task automatic t_sync;
        rd(8'h34, cv);
        wr(8'h01, 16'h0003);
        wr(8'h14, 16'h1234);
        rd(8'h24, rv); chk(rv === 16'h1234, "sync preset");
        rd(8'h34, rv); chk(rv === cv, "unsynced channel kept");
    endtask : t_sync

    // a leading b counts up, b leading a counts down
    task automatic t_phase;
        logic [3:0] steps [5] = '{4'h1, 4'h3, 4'h2, 4'h0, 4'h2};
        wr(8'h20, 16'h0018);
        wr(8'h24, 16'h0100);
        wr(8'h00, 16'h0002);
        for (int i = 0; i < 5; i++) begin
            enc <= steps[i];
            repeat (4) @(posedge sys_clk);
        end
        rd(8'h24, rv); chk(rv === 16'h0103, "phase count four up one down");
        rd(8'h23, rv); chk(rv[6] === 1'b0, "count direction down");
    endtask : t_phase

    // channel 0 period 5 then 7 from its buffer; channel 1 clears along with it
    task automatic t_buffer;
        wr(8'h00, 16'h0000);
        wr(8'h20, 16'h0003);
        wr(8'h10, 16'h0021);
        wr(8'h11, 16'h0003);
        wr(8'h18, 16'h0004);
        wr(8'h1a, 16'h0006);
        wr(8'h14, 16'h0000);
        wr(8'h00, 16'h0003);
        repeat (6) @(posedge sys_clk);
        wr(8'h00, 16'h0000);
        rd(8'h18, rv); chk(rv === 16'h0006, "buffer loaded on match");
        rd(8'h14, cv); chk(cv === 16'h0003, "periodic count");
        rd(8'h24, rv); chk(rv === 16'h0003, "synchronous clear");
        chk(cc_pin_o[0] === 1'b1, "toggled once");
    endtask : t_buffer

    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_overflow();
        t_compare();
        t_capture();
        t_sync();
        t_phase();
        t_buffer();
        wrap_up();
    end

    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
endmodule : tb
